// ---- src/fast_timer_compare_unit.sv ----
// Fast timer compare unit: counter, prescaler, three compares, pins.
// Assumes one clock; the fast source arrives as an enable pulse pin.
module fast_timer_compare_unit
  import fast_timer_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_enable,
  // Fast source tick, one pulse per fast-clock period
  input wire logic fast_pll_source,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare pins, output enable low while driving
  output logic compare_out_a,
  output logic compare_out_a_oe_b,
  output logic compare_out_b,
  output logic compare_out_b_oe_b
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic apply_action(input logic [1:0] mode,
                                        input logic pin);
    case (pin_action_t'(mode))
      pin_toggle: apply_action = ~pin;
      pin_clear: apply_action = 1'b0;
      pin_set: apply_action = 1'b1;
      default: apply_action = pin;
    endcase
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] control_a;
  logic [7:0] control_b;
  logic [7:0] compare_a;
  logic [7:0] compare_b;
  logic [7:0] top_compare;
  logic [7:0] compare_a_live;
  logic [7:0] compare_b_live;
  logic [2:0] pin_control;
  logic [7:0] count;
  logic [7:0] count_shadow;
  logic [2:0] flags;
  logic [2:0] flag_event;
  logic [2:0] flag_delay;
  logic count_write_pending;
  logic [1:0] count_write_wait;
  logic [7:0] count_write_value;
  logic force_a;
  logic force_b;
  logic prescaler_clear;
  logic fast_meta;
  logic fast_sync;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic write_known;
  logic read_known;
  logic [7:0] read_value;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= RESET_BYTE;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (clock_enable)
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    write_known = 1'b1;
    case (aw_addr)
      ADDR_CONTROL_A, ADDR_CONTROL_B, ADDR_COUNT, ADDR_COMPARE_A,
      ADDR_COMPARE_B, ADDR_TOP_COMPARE, ADDR_STATUS,
      ADDR_PIN_CONTROL: write_known = 1'b1;
      default: write_known = 1'b0;
    endcase
  end

  always_comb
  begin
    read_known = 1'b1;
    read_value = RESET_BYTE;
    case (s_axi_araddr)
      // Force bits always read zero
      ADDR_CONTROL_A: read_value = control_a &
        ~(8'h01 << FORCE_MATCH_A) & ~(8'h01 << FORCE_MATCH_B);
      ADDR_CONTROL_B: read_value = control_b & CONTROL_B_WRITE_MASK &
        ~(8'h01 << PRESCALER_RESET);
      ADDR_COUNT: read_value = count_shadow;
      ADDR_COMPARE_A: read_value = compare_a;
      ADDR_COMPARE_B: read_value = compare_b;
      ADDR_TOP_COMPARE: read_value = top_compare;
      ADDR_STATUS: read_value = {5'h00, flags};
      ADDR_PIN_CONTROL: read_value = {5'h00, pin_control};
      default: read_known = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (clock_enable)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, read_value};
        s_axi_rresp <= read_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] next_control_a;
  assign next_control_a = merge_byte(control_a, w_data, w_strb);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      control_a <= RESET_BYTE;
      control_b <= RESET_BYTE;
      compare_a <= RESET_BYTE;
      compare_b <= RESET_BYTE;
      top_compare <= RESET_BYTE;
      pin_control <= '0;
      force_a <= 1'b0;
      force_b <= 1'b0;
      prescaler_clear <= 1'b0;
    end
    else if (clock_enable)
    begin
      force_a <= 1'b0;
      force_b <= 1'b0;
      prescaler_clear <= 1'b0;
      if (do_write && w_strb[0])
        case (aw_addr)
          ADDR_CONTROL_A:
          begin
            control_a <= next_control_a;
            force_a <= next_control_a[FORCE_MATCH_A] &&
              !next_control_a[PWM_ENABLE_A];
            force_b <= next_control_a[FORCE_MATCH_B] &&
              !next_control_a[PWM_ENABLE_B];
          end
          ADDR_CONTROL_B:
          begin
            control_b <= w_data[7:0] & CONTROL_B_WRITE_MASK &
              ~(8'h01 << PRESCALER_RESET);
            prescaler_clear <= w_data[PRESCALER_RESET];
          end
          ADDR_COMPARE_A: compare_a <= w_data[7:0];
          ADDR_COMPARE_B: compare_b <= w_data[7:0];
          ADDR_TOP_COMPARE: top_compare <= w_data[7:0];
          ADDR_PIN_CONTROL: pin_control <= w_data[2:0];
          default: ;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock source and prescaler
  // ----------------------------------------------------------------
  logic async_mode;
  logic base_tick;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] prescale_mask;
  logic [3:0] clock_select;
  logic timer_tick;

  assign async_mode = pin_control[FAST_SOURCE_ENABLE];
  assign clock_select = control_b[CLOCK_SELECT_LSB +: 4];

  // Fast tick pin comes from another domain
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      fast_meta <= 1'b0;
      fast_sync <= 1'b0;
    end
    else if (clock_enable)
    begin
      fast_meta <= fast_pll_source;
      fast_sync <= fast_meta;
    end
  end

  // Base tick from system or fast source
  assign base_tick = async_mode ? fast_sync : 1'b1;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      prescale <= '0;
    else if (clock_enable)
    begin
      if (prescaler_clear)
        prescale <= '0;
      else if (base_tick)
        prescale <= prescale + 1'b1;
    end
  end

  // Divide by two to the power n-1
  assign prescale_mask = (PRESCALE_WIDTH)'((15'h0001 <<
    (clock_select - 4'h1)) - 15'h0001);
  assign timer_tick = (clock_select != CLOCK_STOPPED) && base_tick &&
    !prescaler_clear && ((prescale & prescale_mask) == '0);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic top_hit;
  logic top_clear_mode;
  logic [7:0] next_count;

  assign top_clear_mode = control_b[CLEAR_ON_TOP_MATCH] ||
    control_a[PWM_ENABLE_A] || control_a[PWM_ENABLE_B];
  assign next_count = count + 8'h01;

  // Counter write waits one or two cycles
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      count_write_pending <= 1'b0;
      count_write_wait <= '0;
      count_write_value <= RESET_BYTE;
    end
    else if (clock_enable)
    begin
      if (do_write && w_strb[0] && aw_addr == ADDR_COUNT)
      begin
        count_write_pending <= 1'b1;
        count_write_value <= w_data[7:0];
        count_write_wait <= async_mode ? 2'h1 : 2'h0;
      end
      else if (count_write_pending && count_write_wait != 2'h0)
        count_write_wait <= count_write_wait - 2'h1;
      else
        count_write_pending <= 1'b0;
    end
  end

  logic load_now;
  assign load_now = count_write_pending && count_write_wait == 2'h0;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      count <= COUNT_ZERO;
      top_hit <= 1'b0;
    end
    else if (clock_enable)
    begin
      top_hit <= 1'b0;
      if (load_now)
        count <= count_write_value;
      // Clear one cycle after top match
      else if (top_hit)
        count <= COUNT_ZERO;
      else if (timer_tick)
      begin
        count <= next_count;
        top_hit <= top_clear_mode && next_count == top_compare;
      end
    end
  end

  // Count readback passes an output stage
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      count_shadow <= COUNT_ZERO;
    else if (clock_enable)
      count_shadow <= count;
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  logic match_a;
  logic match_b;
  logic wrap;

  assign wrap = timer_tick && !load_now && !top_hit &&
    count == COUNT_FULL;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      compare_a_live <= RESET_BYTE;
      compare_b_live <= RESET_BYTE;
    end
    else if (clock_enable)
    begin
      // PWM latches held values at top
      if (!control_a[PWM_ENABLE_A] || top_hit)
        compare_a_live <= compare_a;
      if (!control_a[PWM_ENABLE_B] || top_hit)
        compare_b_live <= compare_b;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      match_a <= 1'b0;
      match_b <= 1'b0;
    end
    else if (clock_enable)
    begin
      match_a <= timer_tick && !load_now && !top_hit &&
        next_count == compare_a_live;
      match_b <= timer_tick && !load_now && !top_hit &&
        next_count == compare_b_live;
    end
  end

  // ----------------------------------------------------------------
  // Flags, set wins over write-one-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      flag_event <= '0;
      flag_delay <= '0;
      flags <= '0;
    end
    else if (clock_enable)
    begin
      // Flags set after two sync stages
      flag_event <= {top_hit || wrap, match_b, match_a};
      flag_delay <= flag_event;
      if (do_write && w_strb[0] && aw_addr == ADDR_STATUS)
        flags <= (flags & ~w_data[2:0]) | flag_delay;
      else
        flags <= flags | flag_delay;
    end
  end

  // ----------------------------------------------------------------
  // Pin actions
  // ----------------------------------------------------------------
  logic pin_a;
  logic pin_b;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end
    else if (clock_enable)
    begin
      // Channel A and B actions with current mode
      if (match_a || force_a)
        pin_a <= apply_action(control_a[OUT_MODE_A_HI:OUT_MODE_A_LO],
          pin_a);
      if (match_b || force_b)
        pin_b <= apply_action(control_a[OUT_MODE_B_HI:OUT_MODE_B_LO],
          pin_b);
    end
  end

  assign compare_out_a = pin_a;
  assign compare_out_b = pin_b;

  // Drive only with direction set and mode nonzero
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      compare_out_a_oe_b <= 1'b1;
      compare_out_b_oe_b <= 1'b1;
    end
    else if (clock_enable)
    begin
      compare_out_a_oe_b <= !(pin_control[DIR_PIN_ONE] &&
        control_a[OUT_MODE_A_HI:OUT_MODE_A_LO] != 2'h0);
      compare_out_b_oe_b <= !(pin_control[DIR_PIN_THREE] &&
        control_a[OUT_MODE_B_HI:OUT_MODE_B_LO] != 2'h0);
    end
  end

endmodule

// ---- include/fast_timer_pkg.sv ----
// Package for the fast timer compare unit: register map, fields, codes.
// Assumes a 32-bit AXI4-Lite register bus, one register per word.
package fast_timer_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h10;
  localparam logic [7:0] ADDR_TOP_COMPARE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Control A
  localparam int OUT_MODE_A_HI = 7;
  localparam int OUT_MODE_A_LO = 6;
  localparam int OUT_MODE_B_HI = 5;
  localparam int OUT_MODE_B_LO = 4;
  localparam int FORCE_MATCH_A = 3;
  localparam int FORCE_MATCH_B = 2;
  localparam int PWM_ENABLE_A = 1;
  localparam int PWM_ENABLE_B = 0;
  // Control B
  localparam int CLEAR_ON_TOP_MATCH = 7;
  localparam int PRESCALER_RESET = 6;
  localparam int CLOCK_SELECT_LSB = 0;
  localparam logic [7:0] CONTROL_B_WRITE_MASK = 8'hCF;
  // Status: write one to clear
  localparam int MATCH_FLAG_A = 0;
  localparam int MATCH_FLAG_B = 1;
  localparam int OVERFLOW_FLAG = 2;
  // Pin control
  localparam int DIR_PIN_ONE = 0;
  localparam int DIR_PIN_THREE = 1;
  localparam int FAST_SOURCE_ENABLE = 2;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] CLOCK_STOPPED = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESCALE_WIDTH = 14;

  typedef enum logic [1:0] {
    pin_off,
    pin_toggle,
    pin_clear,
    pin_set
  } pin_action_t;
endpackage

// ---- dv/pin_load.sv ----
// Load on one compare pin: resolves the level seen at the pad.
// Assumes a pull-down on the pad, so an undriven pin reads low.
module pin_load
(
  // Pin from the unit
  input wire logic drive,
  input wire logic drive_oe_b,
  // Pad level
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = drive_oe_b ? 1'h0 : drive;
endmodule

// ---- dv/fast_timer_compare_unit_asserts.sv ----
// Checker for the fast timer compare unit, bound to its top ports.
// Assumes clock_enable held high and byte-lane 0 always written.
module fast_timer_compare_unit_asserts
  import fast_timer_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_enable,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin enables
  input wire logic compare_out_a_oe_b,
  input wire logic compare_out_b_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic bv_q;
  logic [1:0] dir_sh;
  logic [3:0] mode_sh;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic idle_a;
  logic idle_b;
  assign aw_hs = s_axi_awvalid && s_axi_awready && clock_enable;
  assign w_hs = s_axi_wvalid && s_axi_wready && clock_enable;
  assign ar_hs = s_axi_arvalid && s_axi_arready && clock_enable;
  assign idle_a = !dir_sh[0] || mode_sh[3:2] == 2'h0;
  assign idle_b = !dir_sh[1] || mode_sh[1:0] == 2'h0;
  // Shadow of the pin settings, one cycle behind the registers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      aw_q <= 8'h00;
      w_q <= 8'h00;
      bv_q <= 1'h0;
      dir_sh <= 2'h0;
      mode_sh <= 4'h0;
    end
    else
    begin
      if (aw_hs)
        aw_q <= s_axi_awaddr;
      if (w_hs)
        w_q <= s_axi_wdata[7:0];
      bv_q <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_q && aw_q == ADDR_PIN_CONTROL)
        dir_sh <= w_q[1:0];
      if (s_axi_bvalid && !bv_q && aw_q == ADDR_CONTROL_A)
        mode_sh <= w_q[7:4];
    end
  end
  property p_oe_a;
    idle_a && $past(idle_a) |-> compare_out_a_oe_b;
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("pin A driven while disconnected");
  property p_oe_b;
    idle_b && $past(idle_b) |-> compare_out_b_oe_b;
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("pin B driven while disconnected");
  property p_ctl_b;
    ar_hs && s_axi_araddr == ADDR_CONTROL_B
      |=> s_axi_rvalid && s_axi_rdata[6:4] == 3'h0;
  endproperty
  a_ctl_b: assert property (p_ctl_b)
    else $error("control B bits 6..4 not zero");
  property p_ctl_a;
    ar_hs && s_axi_araddr == ADDR_CONTROL_A
      |=> s_axi_rvalid && s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_ctl_a: assert property (p_ctl_a)
    else $error("force bits not read as zero");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");
  property p_b_time;
    aw_hs && w_hs |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("write response not two cycles after request");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write taken while response pending");
  property p_unmapped;
    ar_hs && s_axi_araddr > ADDR_PIN_CONTROL |=> s_axi_rresp == RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
endmodule

bind fast_timer_compare_unit fast_timer_compare_unit_asserts i_chk (
  .clock, .rst_b, .clock_enable, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .compare_out_a_oe_b, .compare_out_b_oe_b);

// ---- dv/test_fast_timer_compare_unit.sv ----
// Self-checking bench for the fast timer compare unit.
// Assumes the unit answers on AXI4-Lite; pins seen through pull-downs.
module test_fast_timer_compare_unit
  import fast_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic clock_enable = 1'h1;
  logic fast_pll_source = 1'h0;
  logic fast_run = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic compare_out_a, compare_out_a_oe_b, pin_a;
  logic compare_out_b, compare_out_b_oe_b, pin_b;
  int errors = 0;
  int checks_done = 0;
  int ex;
  int tol;

  always #2 clock = ~clock;
  // Fast source ticks every other cycle while enabled
  always @(posedge clock)
    fast_pll_source <= fast_run ? ~fast_pll_source : 1'h0;

  fast_timer_compare_unit i_fast_timer_compare_unit (
    .clock, .rst_b, .clock_enable, .fast_pll_source, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compare_out_a, .compare_out_a_oe_b, .compare_out_b,
    .compare_out_b_oe_b);
  pin_load i_pin_load_a (.drive(compare_out_a),
    .drive_oe_b(compare_out_a_oe_b), .level(pin_a));
  pin_load i_pin_load_b (.drive(compare_out_b),
    .drive_oe_b(compare_out_b_oe_b), .level(pin_b));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_open;
    logic w_open;
    @(posedge clock);
    aw_open = 1'h1;
    w_open = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw_open || w_open)
    begin
      @(posedge clock);
      if (aw_open && s_axi_awready === 1'h1)
      begin
        aw_open = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_open && s_axi_wready === 1'h1)
      begin
        w_open = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask

  initial
  begin
    ticks(60000);
    errors++;
    wrap_up();
  end

  initial
  begin
    static logic [1:0] md [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    static logic [3:0] ca [3] = '{4'h0, 4'h2, 4'h1};
    static logic [7:0] cb [3] = '{8'h81, 8'h01, 8'h01};
    ticks(4);
    rst_b <= 1'h1;
    // ------------------------------------------------------------
    // Reset values, refusals, read-as-zero bits
    // ------------------------------------------------------------
    for (int i = 0; i < 8; i++)
      rdchk(8'(i * 4), 32'h0);
    wr(8'h20, 32'h1);
    chk(32'(rs), 32'(RESP_SLVERR));
    rd(8'h20);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(ADDR_CONTROL_B, 32'hFF);
    rdchk(ADDR_CONTROL_B, 32'h8F);
    wr(ADDR_CONTROL_B, 32'h0);
    wr(ADDR_COUNT, 32'h5A);
    ticks(4);
    rdchk(ADDR_COUNT, 32'h5A);
    // ------------------------------------------------------------
    // Forced actions in set, clear and toggle modes, mode written with the force
    // ------------------------------------------------------------
    wr(ADDR_PIN_CONTROL, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CONTROL_A, 32'({md[i], md[i], 4'hC}));
      ticks(3);
      chk(32'(pin_a), 32'(i % 2 == 0));
      chk(32'(pin_b), 32'(i % 2 == 0));
      rdchk(ADDR_CONTROL_A, 32'({md[i], md[i], 4'h0}));
    end
    rdchk(ADDR_STATUS, 32'h0);
    wr(ADDR_CONTROL_A, 32'h7F);
    ticks(3);
    chk(32'({pin_a, pin_b}), 32'h0);
    wr(ADDR_CONTROL_A, 32'h0C);
    ticks(3);
    chk(32'(compare_out_a_oe_b), 32'h1);
    wr(ADDR_PIN_CONTROL, 32'h0);
    wr(ADDR_CONTROL_A, 32'hFC);
    ticks(3);
    chk(32'({compare_out_a_oe_b, compare_out_b_oe_b}), 32'h3);
    chk(32'({pin_a, pin_b}), 32'h0);
    // ------------------------------------------------------------
    // Every clock select code over a fixed span
    // ------------------------------------------------------------
    wr(ADDR_CONTROL_A, 32'h0);
    for (int n = 0; n < 16; n++)
    begin
      wr(ADDR_COUNT, 32'h0);
      ticks(3);
      wr(ADDR_CONTROL_B, 32'h40 | n);
      ticks(128);
      wr(ADDR_CONTROL_B, 32'h0);
      ticks(3);
      rd(ADDR_COUNT);
      ex = n == 0 ? 0 : 128 >> (n - 1);
      tol = n == 0 ? 0 : 1 + (8 >> (n - 1));
      chk(32'(rv <= ex + tol && rv + tol >= ex), 32'h1);
    end
    // ------------------------------------------------------------
    // Top compare wrap in clear and PWM modes, then free count
    // ------------------------------------------------------------
    wr(ADDR_TOP_COMPARE, 32'h5);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_STATUS, 32'h7);
      wr(ADDR_CONTROL_A, 32'(ca[i]));
      wr(ADDR_CONTROL_B, 32'(cb[i]));
      repeat (3)
      begin
        rd(ADDR_COUNT);
        chk(32'(rv <= 32'h5), 32'h1);
      end
      wr(ADDR_CONTROL_B, 32'h0);
      ticks(6);
      rd(ADDR_STATUS);
      chk(32'(rv[OVERFLOW_FLAG]), 32'h1);
    end
    wr(ADDR_CONTROL_A, 32'h2);
    wr(ADDR_COMPARE_A, 32'h33);
    rdchk(ADDR_COMPARE_A, 32'h33);
    wr(ADDR_CONTROL_A, 32'h0);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CONTROL_B, 32'h1);
    clock_enable <= 1'h0;
    ticks(40);
    clock_enable <= 1'h1;
    ticks(20);
    wr(ADDR_CONTROL_B, 32'h0);
    rd(ADDR_COUNT);
    chk(32'(rv > 32'h5 && rv < 32'h30), 32'h1);
    // ------------------------------------------------------------
    // Matches only by counting; flags and toggles follow
    // ------------------------------------------------------------
    wr(ADDR_PIN_CONTROL, 32'h3);
    wr(ADDR_CONTROL_A, 32'hFC);
    wr(ADDR_CONTROL_A, 32'h50);
    wr(ADDR_COMPARE_A, 32'h10);
    wr(ADDR_COMPARE_B, 32'h12);
    wr(ADDR_STATUS, 32'h7);
    wr(ADDR_COUNT, 32'h10);
    wr(ADDR_COUNT, 32'h12);
    ticks(8);
    rdchk(ADDR_STATUS, 32'h0);
    chk(32'({pin_a, pin_b}), 32'h3);
    wr(ADDR_COUNT, 32'h0E);
    wr(ADDR_CONTROL_B, 32'h1);
    ticks(6);
    wr(ADDR_CONTROL_B, 32'h0);
    ticks(8);
    rdchk(ADDR_STATUS, 32'h3);
    chk(32'({pin_a, pin_b}), 32'h0);
    // ------------------------------------------------------------
    // Fast source: idle source holds, running source counts
    // ------------------------------------------------------------
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_PIN_CONTROL, 32'h4);
    wr(ADDR_CONTROL_B, 32'h1);
    ticks(40);
    wr(ADDR_CONTROL_B, 32'h0);
    ticks(3);
    rdchk(ADDR_COUNT, 32'h0);
    fast_run <= 1'h1;
    wr(ADDR_CONTROL_B, 32'h1);
    ticks(64);
    wr(ADDR_CONTROL_B, 32'h0);
    ticks(3);
    fast_run <= 1'h0;
    rd(ADDR_COUNT);
    chk(32'(rv >= 32'd28 && rv <= 32'd40), 32'h1);
    wrap_up();
  end
endmodule
